/* File: logic/pcs_consts.svh */
// Operation
// - high readback: upper two bits zero, pc[13:8]
// - low read returns pc low, latches high
// - sixteen-entry hidden return-address stack
// - four-bit pointer, readable, not writable
// - call or interrupt acknowledge pushes, pointer increments
// - return pops, decrements, reloads program counter
// - reset sets pointer to zero
// - full stack withholds interrupt acknowledge until return
// - call on full stack overwrites oldest
// - overflow flag on full call, empty return
// - overflow flag cleared only by software or reset
// - calls wrap at sixteen, seventeenth sets flag
// - empty return wraps to fifteen, sets flag
// - pointer bits six to four read zero
// - alu results update status flags
// - program memory 16K by 16, two address sources
// - reset loads program counter with zero
// - table pointer low/high form full address
// - table read: low to destination, high register
// - table read takes two instruction cycles
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// register byte offsets on the bus
`define PCS_OFF_PCL      8'h00
`define PCS_OFF_PCH      8'h04
`define PCS_OFF_SP       8'h08
`define PCS_OFF_TPL      8'h0C
`define PCS_OFF_TPH      8'h10
`define PCS_OFF_TBH      8'h14
`define PCS_OFF_STAT     8'h18

// field positions
`define PCS_OSF_BIT      7
`define PCS_ST_C         0
`define PCS_ST_AC        1
`define PCS_ST_Z         2
`define PCS_ST_OV        3

// reset values
`define PCS_PC_RESET     14'h0000
`define PCS_SP_RESET     4'h0
`define PCS_DEPTH_FULL   5'h10

// timing: one instruction cycle is four system clocks
`define PCS_INSTR_CLKS   4
`define PCS_TBL_INSTR    2
`define PCS_TBL_CLKS     (`PCS_INSTR_CLKS * `PCS_TBL_INSTR)

`endif

/* File: logic/pcs_pkg.sv */
package pcs_pkg;
  typedef logic [13:0] pcs_addr_t;
  typedef logic [3:0]  pcs_ptr_t;
  typedef enum logic [1:0]
  {
    pcs_tbl_idle = 2'b01,
    pcs_tbl_busy = 2'b10
  } pcs_tbl_state_t;
endpackage : pcs_pkg

/* File: logic/pcs_stack_table.sv */
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`include "pcs_consts.svh"

module pcs_stack_table
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              pc_step,
  input  wire logic              pc_jump,
  input  wire pcs_pkg::pcs_addr_t pc_jump_addr,
  input  wire logic              op_call,
  input  wire pcs_pkg::pcs_addr_t call_target,
  input  wire logic              op_subroutine_exit,
  input  wire logic              op_interrupt_exit,
  input  wire logic              irq_en,
  input  wire logic              irq_req,
  input  wire pcs_pkg::pcs_addr_t irq_vector,
  output logic                   irq_ack,
  output pcs_pkg::pcs_addr_t     pc_out,
  output logic [15:0]            fetch_word,
  input  wire logic              prog_we,
  input  wire pcs_pkg::pcs_addr_t prog_addr,
  input  wire logic [15:0]       prog_wdata,
  input  wire logic              tbl_start,
  input  wire logic              tbl_extended,
  output logic                   tbl_busy,
  output logic                   tbl_done,
  output logic [7:0]             tbl_low_byte,
  output logic                   tbl_to_sector0,
  input  wire logic              alu_valid,
  input  wire logic [7:0]        alu_result,
  input  wire logic              alu_carry,
  input  wire logic              alu_aux,
  input  wire logic              alu_ovf,
  output pcs_pkg::pcs_ptr_t      stack_ptr,
  output logic                   stack_overflow_flag
);
  import pcs_pkg::*;

  localparam int tbl_lat = `PCS_TBL_CLKS;

  // pointer step with natural 4-bit wrap
  function automatic pcs_ptr_t pcs_step_ptr(input pcs_ptr_t p, input logic up);
    pcs_step_ptr = up ? 4'(p + 4'h1) : 4'(p - 4'h1);
  endfunction : pcs_step_ptr

  // register state
  pcs_addr_t      pc;
  pcs_addr_t      stack_mem [0:15];
  logic [4:0]     depth;
  logic           irq_pend;
  logic [7:0]     pc_high_hold;
  logic [7:0]     tbl_ptr_low;
  logic [5:0]     tbl_ptr_high;
  logic [7:0]     table_high_byte;
  logic [3:0]     status_flags;
  logic [15:0]    prog_mem [0:16383];
  logic [15:0]    tbl_word;
  logic [3:0]     tbl_cnt;
  pcs_tbl_state_t tbl_state;
  logic           bus_ack;

  // decoded operations
  logic           do_pop;
  logic           do_call;
  logic           ack_now;
  logic           stack_full;
  logic           stack_empty;
  pcs_addr_t      pop_word;
  pcs_addr_t      tbl_addr;
  logic           bus_first;
  logic           wr_acc;
  logic           osf_wr;
  logic [31:0]    next_readdata;

  // returns outrank calls; an acknowledge only takes a cycle with no call or return, and outranks a jump or step
  assign stack_full  = (depth == `PCS_DEPTH_FULL);
  assign stack_empty = (depth == 5'h00);
  assign do_pop      = op_subroutine_exit | op_interrupt_exit;
  assign do_call     = op_call & ~do_pop;
  assign ack_now     = irq_pend & ~stack_full & ~do_pop & ~op_call;
  assign pop_word    = stack_mem[pcs_step_ptr(stack_ptr, 1'b0)];
  assign tbl_addr    = {tbl_ptr_high, tbl_ptr_low};

  // one wait state per access; side effects of a read happen once
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign bus_first       = (avs_read | avs_write) & ~bus_ack;
  assign wr_acc          = avs_write & bus_ack & avs_byteenable[0];
  assign osf_wr          = wr_acc & (avs_address == `PCS_OFF_SP);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      bus_ack <= 1'b0;
    else
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `PCS_OFF_PCL:  next_readdata = {24'h000000, pc[7:0]};
      `PCS_OFF_PCH:  next_readdata = {24'h000000, pc_high_hold};
      `PCS_OFF_SP:   next_readdata = {24'h000000, stack_overflow_flag, 3'h0, stack_ptr};
      `PCS_OFF_TPL:  next_readdata = {24'h000000, tbl_ptr_low};
      `PCS_OFF_TPH:  next_readdata = {26'h0000000, tbl_ptr_high};
      `PCS_OFF_TBH:  next_readdata = {24'h000000, table_high_byte};
      `PCS_OFF_STAT: next_readdata = {28'h0000000, status_flags};
      default:       next_readdata = 32'h0000_0000;
    endcase
  end

  // read data captured on the first cycle, stands until the accept edge
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (bus_first && avs_read)
      avs_readdata <= next_readdata;
  end

  // low byte read snapshots the high byte, so a pair reads coherently
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pc_high_hold <= 8'h00;
    else if (bus_first && avs_read && avs_address == `PCS_OFF_PCL)
      pc_high_hold <= {2'b00, pc[13:8]};
  end

  // program counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pc <= `PCS_PC_RESET;
    else if (do_pop)
      pc <= pop_word;
    else if (do_call)
      pc <= call_target;
    else if (ack_now)
      pc <= irq_vector;
    else if (pc_jump)
      pc <= pc_jump_addr;
    else if (pc_step)
      pc <= 14'(pc + 14'h0001);
  end

  // hidden stack array, only written by a push; the oldest is overwritten when full
  always_ff @(posedge core_clk)
  begin
    if (do_call || ack_now)
      stack_mem[stack_ptr] <= pc;
  end

  // pointer moves in the same clock as the push or pop
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      stack_ptr <= `PCS_SP_RESET;
    else if (do_pop)
      stack_ptr <= pcs_step_ptr(stack_ptr, 1'b0);
    else if (do_call || ack_now)
      stack_ptr <= pcs_step_ptr(stack_ptr, 1'b1);
  end

  // occupancy count tells full from empty when the pointer wraps
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      depth <= 5'h00;
    else if (do_pop && !stack_empty)
      depth <= 5'(depth - 5'h01);
    else if ((do_call || ack_now) && !stack_full)
      depth <= 5'(depth + 5'h01);
  end

  // sticky overflow flag; a hardware set beats a software clear
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      stack_overflow_flag <= 1'b0;
    else if ((do_call && stack_full) || (do_pop && stack_empty))
      stack_overflow_flag <= 1'b1;
    else if (osf_wr)
      stack_overflow_flag <= avs_writedata[`PCS_OSF_BIT];
  end

  // pending interrupt waits while the stack is full
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      irq_pend <= 1'b0;
      irq_ack  <= 1'b0;
    end
    else
    begin
      irq_pend <= (irq_pend & ~ack_now) | (irq_req & irq_en);
      irq_ack  <= ack_now;
    end
  end

  // table pointer and table high byte registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tbl_ptr_low  <= 8'h00;
      tbl_ptr_high <= 6'h00;
    end
    else if (wr_acc && avs_address == `PCS_OFF_TPL)
      tbl_ptr_low <= avs_writedata[7:0];
    else if (wr_acc && avs_address == `PCS_OFF_TPH)
      tbl_ptr_high <= avs_writedata[5:0];
  end

  // completing table read wins over a software write in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      table_high_byte <= 8'h00;
    else if (tbl_state == pcs_tbl_busy && tbl_cnt == 4'(tbl_lat - 2))
      table_high_byte <= tbl_word[15:8];
    else if (wr_acc && avs_address == `PCS_OFF_TBH)
      table_high_byte <= avs_writedata[7:0];
  end

  // program memory: loader write, fetch by pc, table word by pointer
  always_ff @(posedge core_clk)
  begin
    if (prog_we)
      prog_mem[prog_addr] <= prog_wdata;
    fetch_word <= prog_mem[pc];
    if (tbl_start && tbl_state == pcs_tbl_idle)
      tbl_word <= prog_mem[tbl_addr];
  end

  // table read sequencer: start is ignored while busy
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tbl_state      <= pcs_tbl_idle;
      tbl_cnt        <= 4'h0;
      tbl_done       <= 1'b0;
      tbl_low_byte   <= 8'h00;
      tbl_to_sector0 <= 1'b0;
    end
    else
    begin
      tbl_done <= 1'b0;
      case (tbl_state)
        pcs_tbl_idle:
        begin
          if (tbl_start)
          begin
            tbl_state      <= pcs_tbl_busy;
            tbl_cnt        <= 4'h0;
            tbl_to_sector0 <= ~tbl_extended;
          end
        end
        pcs_tbl_busy:
        begin
          tbl_cnt <= 4'(tbl_cnt + 4'h1);
          if (tbl_cnt == 4'(tbl_lat - 2))
          begin
            tbl_state    <= pcs_tbl_idle;
            tbl_done     <= 1'b1;
            tbl_low_byte <= tbl_word[7:0];
          end
        end
        default:
          tbl_state <= pcs_tbl_idle;
      endcase
    end
  end

  assign tbl_busy = (tbl_state == pcs_tbl_busy);

  // status flags follow every alu result; software may also write them
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      status_flags <= 4'h0;
    else if (alu_valid)
    begin
      status_flags[`PCS_ST_C]  <= alu_carry;
      status_flags[`PCS_ST_AC] <= alu_aux;
      status_flags[`PCS_ST_Z]  <= (alu_result == 8'h00);
      status_flags[`PCS_ST_OV] <= alu_ovf;
    end
    else if (wr_acc && avs_address == `PCS_OFF_STAT)
      status_flags <= avs_writedata[3:0];
  end

  assign pc_out = pc;

  // checks beside the logic
  a_call_ptr_adv: assert property (@(posedge core_clk) disable iff (!rst_n)
    do_call |=> stack_ptr == pcs_step_ptr($past(stack_ptr), 1'b1))
    else $error("call did not advance stack pointer");

  a_pop_ptr_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
    do_pop |=> (stack_ptr == pcs_step_ptr($past(stack_ptr), 1'b0)) && (pc == $past(pop_word)))
    else $error("return did not pop pointer and pc");

  a_full_call_osf: assert property (@(posedge core_clk) disable iff (!rst_n)
    (do_call && stack_full) |=> stack_overflow_flag && stack_full)
    else $error("full call did not set overflow flag");

  a_osf_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    (stack_overflow_flag && !osf_wr) |=> stack_overflow_flag)
    else $error("overflow flag cleared by hardware");

  a_irq_full_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (stack_full && !do_pop) |=> !irq_ack)
    else $error("interrupt acknowledged with full stack");

  a_table_latency: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tbl_start && tbl_state == pcs_tbl_idle) |=> !tbl_done ##(tbl_lat - 1) tbl_done)
    else $error("table read not done in two instruction cycles");

  a_pch_top_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && avs_address == `PCS_OFF_PCH) |-> avs_readdata[31:6] == 26'h0)
    else $error("high readback upper bits not zero");

  a_sp_gap_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && avs_address == `PCS_OFF_SP) |-> avs_readdata[6:4] == 3'h0)
    else $error("pointer register bits six to four not zero");

  a_reset_vector: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(rst_n) |-> (pc == `PCS_PC_RESET) && (stack_ptr == `PCS_SP_RESET))
    else $error("reset did not clear pc and pointer");

  a_alu_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    alu_valid |=> status_flags[`PCS_ST_Z] == ($past(alu_result) == 8'h00))
    else $error("zero flag does not follow alu result");

endmodule : pcs_stack_table

/* File: dv/pcs_seq_model.sv */
`timescale 1ns/10ps
module pcs_seq_model
(
  input  wire logic           core_clk,
  input  wire logic           irq_ack,
  output logic                op_call,
  output pcs_pkg::pcs_addr_t  call_target,
  output logic                op_subroutine_exit,
  output logic                op_interrupt_exit,
  output logic                pc_jump,
  output pcs_pkg::pcs_addr_t  pc_jump_addr,
  output logic                irq_en,
  output logic                irq_req
);
  import pcs_pkg::*;

  // idle sequencer, no ops pending
  initial
  begin
    {op_call, op_subroutine_exit, op_interrupt_exit, pc_jump, irq_en, irq_req} = '0;
    call_target = '0;
    pc_jump_addr = '0;
  end

  // late safety clear; the device keeps its own pending copy of the request
  always @(posedge core_clk)
  begin
    if (irq_ack === 1'b1)
      irq_req <= 1'b0;
  end

  // one-cycle call pulse; target scrambled once released
  task automatic pulse_call(input pcs_addr_t t);
    @(posedge core_clk);
    op_call <= 1'b1;
    call_target <= t;
    @(posedge core_clk);
    op_call <= 1'b0;
    call_target <= ~t;
  endtask : pulse_call

  // one-cycle exit pulse, subroutine or interrupt flavour
  task automatic pulse_exit(input logic intr);
    @(posedge core_clk);
    op_subroutine_exit <= ~intr;
    op_interrupt_exit <= intr;
    @(posedge core_clk);
    op_subroutine_exit <= 1'b0;
    op_interrupt_exit <= 1'b0;
  endtask : pulse_exit

  task automatic jump(input pcs_addr_t a);
    @(posedge core_clk);
    pc_jump <= 1'b1;
    pc_jump_addr <= a;
    @(posedge core_clk);
    pc_jump <= 1'b0;
    pc_jump_addr <= ~a;
  endtask : jump

  // one-cycle request event; a level held past the acknowledge would re-arm it
  task automatic raise_irq;
    @(posedge core_clk);
    irq_en <= 1'b1;
    irq_req <= 1'b1;
    @(posedge core_clk);
    irq_req <= 1'b0;
  endtask : raise_irq
endmodule : pcs_seq_model

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`include "pcs_consts.svh"
module testbench;
  import pcs_pkg::*;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

  localparam pcs_addr_t VEC = 14'h0004;
  logic        core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, tbl_low_byte, alu_result, q;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        pc_step, pc_jump, op_call, op_subroutine_exit, op_interrupt_exit;
  logic        irq_en, irq_req, irq_ack, prog_we, tbl_start, tbl_extended;
  logic        tbl_busy, tbl_done, tbl_to_sector0, stack_overflow_flag;
  logic        alu_valid, alu_carry, alu_aux, alu_ovf;
  pcs_addr_t   pc_jump_addr, call_target, irq_vector, pc_out, prog_addr;
  logic [15:0] fetch_word, prog_wdata;
  pcs_ptr_t    stack_ptr;
  int          n_errors, comparisons, n_ack, i;

  pcs_stack_table i_dut (.*);
  pcs_seq_model   i_seq (.*);

  // free-running system clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // count acknowledge pulses as they are sampled
  always @(posedge core_clk)
    if (irq_ack === 1'b1) n_ack++;

  task automatic close_out;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // one bus access; request held until a rising edge samples waitrequest low,
  // data taken and request dropped at that same edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20)
    begin
      n_errors++;
      $display("[FAIL] %0t bus hang", $time);
      close_out();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // table fetch; done must land eight clocks after the start cycle
  task automatic tbl(input logic ext);
    int n;
    @(posedge core_clk);
    tbl_start <= 1'b1;
    tbl_extended <= ext;
    @(posedge core_clk);
    tbl_start <= 1'b0;
    #1;
    `CHK(tbl_busy, 1'b1)
    for (n = 1; n < 20 && tbl_done !== 1'b1; n++) @(posedge core_clk) #1;
    `CHK(n, 8)
    `CHK(tbl_busy, 1'b0)
    `CHK(tbl_low_byte, 8'hEF)
    `CHK(tbl_to_sector0, ~ext)
    if (n == 20) close_out();
  endtask : tbl

  initial
  begin
    {rst_n, avs_read, avs_write, pc_step, prog_we, tbl_start, tbl_extended} = '0;
    {alu_valid, alu_carry, alu_aux, alu_ovf, alu_result} = '0;
    {avs_address, avs_writedata, prog_addr, prog_wdata} = '0;
    avs_byteenable = 4'hF;
    irq_vector = VEC;
    {n_errors, comparisons, n_ack} = '0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(0, `PCS_OFF_PCL, 8'h00);
    `CHK(q, 8'h00)
    bus(0, `PCS_OFF_PCH, 8'h00);
    `CHK(q, 8'h00)
    // sixteen calls fill the stack and wrap the pointer with no flag
    for (i = 0; i < 16; i++)
    begin
      i_seq.pulse_call(pcs_addr_t'(14'h100 + i));
      #1;
      `CHK(stack_ptr, pcs_ptr_t'((i + 1) % 16))
      `CHK(pc_out, pcs_addr_t'(14'h100 + i))
      `CHK(stack_overflow_flag, 1'b0)
    end
    // full stack holds off the acknowledge until a return frees a level
    i_seq.raise_irq();
    repeat (12) @(posedge core_clk);
    `CHK(n_ack, 0)
    i_seq.pulse_exit(1'b0);
    #1;
    `CHK(stack_ptr, 4'hF)
    `CHK(pc_out, 14'h010E)
    for (i = 0; i < 20 && n_ack == 0; i++) @(posedge core_clk);
    #1;
    `CHK(n_ack, 1)
    if (n_ack == 0) close_out();
    `CHK(pc_out, VEC)
    `CHK(stack_ptr, 4'h0)
    // call on a full stack still runs and raises the flag
    i_seq.pulse_call(14'h01FF);
    #1;
    `CHK(stack_ptr, 4'h1)
    `CHK(stack_overflow_flag, 1'b1)
    bus(1, `PCS_OFF_SP, 8'h7E);
    bus(0, `PCS_OFF_SP, 8'h00);
    `CHK(q, 8'h01)
    // unwind: the very first saved address was overwritten
    for (i = 1; i <= 16; i++)
    begin
      i_seq.pulse_exit(i[0]);
      #1;
      `CHK(pc_out, (i == 1) ? VEC : pcs_addr_t'(14'h110 - i))
      `CHK(stack_ptr, pcs_ptr_t'(17 - i))
      `CHK(stack_overflow_flag, 1'b0)
    end
    // mid-run reset, then returns on an empty stack
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(0, `PCS_OFF_SP, 8'h00);
    `CHK(q, 8'h00)
    for (i = 1; i <= 16; i++)
    begin
      i_seq.pulse_exit(1'b0);
      #1;
      `CHK(stack_ptr, pcs_ptr_t'(16 - i))
      `CHK(stack_overflow_flag, 1'b1)
    end
    // low read snapshots the high byte for the later high read
    @(posedge core_clk);
    prog_we <= 1'b1;
    prog_addr <= 14'h3F06;
    prog_wdata <= 16'hBEEF;
    @(posedge core_clk);
    prog_we <= 1'b0;
    i_seq.jump(14'h02A5);
    bus(0, `PCS_OFF_PCL, 8'h00);
    `CHK(q, 8'hA5)
    i_seq.jump(14'h3F06);
    bus(0, `PCS_OFF_PCH, 8'h00);
    `CHK(q, 8'h02)
    `CHK(fetch_word, 16'hBEEF)
    bus(0, `PCS_OFF_PCL, 8'h00);
    bus(0, `PCS_OFF_PCH, 8'h00);
    `CHK(q, 8'h3F)
    // table fetch in both flavours from a pointer set by software
    bus(1, `PCS_OFF_TPL, 8'h06);
    bus(1, `PCS_OFF_TPH, 8'h3F);
    for (i = 0; i < 2; i++)
    begin
      bus(1, `PCS_OFF_TBH, 8'h00);
      tbl(i[0]);
      bus(0, `PCS_OFF_TBH, 8'h00);
      `CHK(q, 8'hBE)
    end
    // zero result with carry and overflow
    @(posedge core_clk);
    {alu_valid, alu_carry, alu_ovf} <= 3'b111;
    @(posedge core_clk);
    alu_valid <= 1'b0;
    bus(0, `PCS_OFF_STAT, 8'h00);
    `CHK(q, 8'h0D)
    bus(0, 8'h1C, 8'h00);
    `CHK(q, 8'h00)
    close_out();
  end
endmodule : testbench
